// >>> shared/synth_regs_pkg.sv
// shared constants for the synthesizer configuration/status register link
package synth_regs_pkg;
  localparam int REG_W   = 27;                // register payload width
  localparam int FRAME_W = 32;                // one serial frame
  localparam int ADDR_W  = 4;                 // register index width
  localparam int RW_BIT  = 31;                // frame bit: 1 = read
  localparam int ADDR_HI = 30;                // frame address field
  localparam int ADDR_LO = 27;
  localparam int HEAD_BITS = 5;               // rw bit plus address
  localparam int CNT_W   = 6;                 // frame bit counter width

  // register indices
  localparam logic [3:0] OFS_LOW_POWER = 4'h5;
  localparam logic [3:0] OFS_CAL_MOD   = 4'h6;
  localparam logic [3:0] OFS_PIN_FAST  = 4'h7;
  localparam logic [3:0] OFS_REGULATOR = 4'h8;
  localparam logic [3:0] OFS_TEST_INIT = 4'h9;
  localparam logic [3:0] OFS_STATUS    = 4'ha;

  // low-power register fields
  localparam int SECOND_OUTPUT_BUFFER_LOW_POWER = 4;
  localparam int RF_SPLITTER_LOW_POWER          = 2;
  localparam int REFERENCE_BUFFER_LOW_POWER     = 0;
  localparam logic [26:0] LOW_POWER_USED_MASK   = 27'h000_0015;

  // calibration / modulator register fields
  localparam int DITHER_ENABLE             = 26;
  localparam int MODULATOR_ORDER_LO        = 22;
  localparam int CALIBRATION_AUTO_RESTART  = 20;
  localparam int OSCILLATOR_SELECT_LO      = 18;
  localparam int MANUAL_SUBBAND_LO         = 13;
  localparam int TEMP_COMPENSATION         = 12;
  localparam int PRECHARGE_SLOTS_LO        = 10;
  localparam int CALIBRATION_ACCURACY_BOOST = 9;
  localparam int CAL_DIVIDER_LO            = 0;
  localparam logic [8:0] CAL_DIVIDER_MAX   = 9'h1ff;
  localparam logic [1:0] EXTRA_SLOTS       = 2'h2;

  // pin and fast-lock register fields
  localparam int SHARED_PIN_HIGH_Z         = 25;
  localparam int SHARED_PIN_DRIVER_TYPE    = 24;
  localparam int SERIAL_OUT_DISABLE        = 23;
  localparam int SHARED_PIN_SOURCE_LO      = 21;
  localparam int FAST_LOCK_ENABLE          = 18;
  localparam int FAST_LOCK_PUMP_CURRENT_LO = 13;
  localparam int FAST_LOCK_DURATION_LO     = 0;

  // regulator register fields
  localparam int SECOND_POWERDOWN_PIN_IGNORE  = 26;
  localparam int HIGH_VOLTAGE_REGULATOR_LO    = 0;

  // status word layout: started[17:13], overcurrent[12:8], lock[7], osc[6:5], band[4:0]
  localparam int STATUS_PAD_W = 9;

  // host controller command port
  localparam logic [3:0] HOST_CMD    = 4'h0;
  localparam logic [3:0] HOST_STATUS = 4'h1;
  localparam logic [3:0] HOST_RDATA  = 4'h2;

  // what drives the shared pin outside a read
  typedef enum logic [1:0] {
    SRC_LOCK, SRC_VCO_DIV, SRC_CAL_DIV, SRC_FAST_CLK
  } pin_source_e;
endpackage : synth_regs_pkg

// >>> shared/synth_spi_if.sv
// serial link between host controller and synthesizer register bank
`timescale 1ns/10ps
interface synth_spi_if;
  logic sclk;       // serial clock, made by the host
  logic frame_n;    // frame select, low during a frame
  logic sdi;        // host to device data
  logic pin_out;    // shared lock / serial-out pin value
  logic pin_oe;     // shared pin output enable
  logic pin_level;  // resolved wire, pulled high when undriven

  assign pin_level = pin_oe ? pin_out : 1'b1;

  modport device (input sclk, input frame_n, input sdi, output pin_out, output pin_oe);
  modport host (output sclk, output frame_n, output sdi, input pin_level);
endinterface : synth_spi_if

// >>> hw/synth_config_device.sv
// synthesizer configuration and status register bank, device end of the link
// Notes on behaviour
// - three low-power bits, one means low
// - host writes zero to reserved bits
// - dither bit enables modulator dithering
// - order field: 00 third, 01 second, 10 first, 11 fourth
// - auto-restart bit; unsupported variants keep zero
// - manual oscillator select and sub-band fields
// - temperature compensation enable for calibration
// - precharge slots: code plus one
// - accuracy bit adds two calibration slots
// - divider ratio, zero means 511
// - high-z bit floats shared pin
// - driver type: open-drain or push-pull
// - serial-out auto switch unless disabled
// - source select: lock, vco div, cal div, fast clock
// - fast lock via pin, pump current field
// - fast lock lasts duration field pfd cycles
// - ignore second powerdown pin, first controls both
// - high-voltage regulator level code
// - host writes test register all zero
// - status start-up and overcurrent flags
// - status lock bit mirrors lock detector
// - status returns calibrated oscillator and sub-band
// - host follows first programming order
`timescale 1ns/10ps
module synth_config_device
  import synth_regs_pkg::*;
#(
  parameter int DUR_W = 13                      // fast-lock duration width
) (
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  synth_spi_if.device                spi,
  input  wire logic                  pll_locked,
  input  wire logic                  vco_divider_clock,
  input  wire logic                  cal_divider_clock,
  input  wire logic                  fast_lock_clock,
  input  wire logic                  fast_lock_switch_pin,
  input  wire logic                  rf1_powerdown_pin,
  input  wire logic                  rf2_powerdown_pin,
  input  wire logic                  pfd_tick,
  input  wire logic [4:0]            regulator_started,
  input  wire logic [4:0]            regulator_overcurrent,
  input  wire logic [1:0]            calibrated_oscillator,
  input  wire logic [4:0]            calibrated_subband,
  output logic [REG_W-1:0]           low_power_control,
  output logic [REG_W-1:0]           calibration_modulator_config,
  output logic [REG_W-1:0]           pin_and_fast_lock_config,
  output logic [REG_W-1:0]           regulator_config,
  output logic [REG_W-1:0]           test_initialization,
  output logic [2:0]                 modulator_stages,
  output logic [8:0]                 calibration_divide_ratio,
  output logic [2:0]                 precharge_slot_count,
  output logic [1:0]                 calibration_extra_slots,
  output logic                       rf1_powered_down,
  output logic                       rf2_powered_down,
  output logic                       fast_lock_active,
  output logic [4:0]                 fast_lock_pump_current
);
  import synth_regs_pkg::*;

  // register read decode; status is assembled live from the inputs
  function automatic logic [REG_W-1:0] read_word(input logic [3:0] idx,
                                                 input logic [REG_W-1:0] r5,
                                                 input logic [REG_W-1:0] r6,
                                                 input logic [REG_W-1:0] r7,
                                                 input logic [REG_W-1:0] r8,
                                                 input logic [REG_W-1:0] r9,
                                                 input logic [REG_W-1:0] st);
    case (idx)
      OFS_LOW_POWER: read_word = r5;
      OFS_CAL_MOD:   read_word = r6;
      OFS_PIN_FAST:  read_word = r7;
      OFS_REGULATOR: read_word = r8;
      OFS_TEST_INIT: read_word = r9;
      OFS_STATUS:    read_word = st;
      default:       read_word = '0;            // unmapped reads as zero
    endcase
  endfunction : read_word

  // link state
  logic                 sclk_q;                 // last sampled serial clock
  logic                 frame_q;                // last sampled frame select
  logic [FRAME_W-1:0]   shift_in;               // incoming frame bits
  logic [CNT_W-1:0]     bit_cnt;                // bits seen this frame
  logic                 reading;                // shared pin carries read data
  logic [REG_W-1:0]     shift_out;              // read data, msb on the pin
  logic                 next_sclk_q;
  logic                 next_frame_q;
  logic [FRAME_W-1:0]   next_shift_in;
  logic [CNT_W-1:0]     next_bit_cnt;
  logic                 next_reading;
  logic [REG_W-1:0]     next_shift_out;
  logic [REG_W-1:0]     next_low_power, next_cal_mod, next_pin_fast;
  logic [REG_W-1:0]     next_regulator, next_test_init;
  logic [REG_W-1:0]     status_word;            // read-only status view
  logic [FRAME_W-1:0]   head;                   // frame after this bit

  // status bits come straight from the analog side, never stored
  assign status_word = {{STATUS_PAD_W{1'b0}}, regulator_started,
                        regulator_overcurrent, pll_locked,
                        calibrated_oscillator, calibrated_subband};

  // next-state logic of the serial slave and the register file
  always_comb begin
    head           = {shift_in[FRAME_W-2:0], spi.sdi};
    next_sclk_q    = spi.sclk;
    next_frame_q   = spi.frame_n;
    next_shift_in  = shift_in;
    next_bit_cnt   = bit_cnt;
    next_reading   = reading;
    next_shift_out = shift_out;
    next_low_power = low_power_control;
    next_cal_mod   = calibration_modulator_config;
    next_pin_fast  = pin_and_fast_lock_config;
    next_regulator = regulator_config;
    next_test_init = test_initialization;
    if (spi.frame_n) begin
      // frame closed: commit only a full-length write
      next_bit_cnt = '0;
      next_reading = 1'b0;
      if (!frame_q && bit_cnt == CNT_W'(FRAME_W) && !shift_in[RW_BIT]) begin
        case (shift_in[ADDR_HI:ADDR_LO])
          OFS_LOW_POWER: next_low_power = shift_in[REG_W-1:0];
          OFS_CAL_MOD:   next_cal_mod   = shift_in[REG_W-1:0];
          OFS_PIN_FAST:  next_pin_fast  = shift_in[REG_W-1:0];
          OFS_REGULATOR: next_regulator = shift_in[REG_W-1:0];
          OFS_TEST_INIT: next_test_init = shift_in[REG_W-1:0];
          default: begin
            // status and unmapped writes are dropped
          end
        endcase
      end
    end else if (spi.sclk && !sclk_q) begin
      // rising serial clock: take one bit, msb first
      next_shift_in = head;
      if (bit_cnt != CNT_W'(FRAME_W)) begin
        next_bit_cnt = bit_cnt + 1'b1;
      end
      // header complete: a read turns the pin to data unless serial-out is disabled
      if (bit_cnt == CNT_W'(HEAD_BITS - 1) && head[HEAD_BITS-1] &&
          !pin_and_fast_lock_config[SERIAL_OUT_DISABLE]) begin
        next_reading   = 1'b1;
        next_shift_out = read_word(head[ADDR_W-1:0], low_power_control,
                                   calibration_modulator_config,
                                   pin_and_fast_lock_config, regulator_config,
                                   test_initialization, status_word);
      end
    end else if (!spi.sclk && sclk_q && reading && bit_cnt > CNT_W'(HEAD_BITS)) begin
      // falling serial clock: present the next read bit; the fall right after
      // the header keeps the top bit up for the host's first sample
      next_shift_out = {shift_out[REG_W-2:0], 1'b0};
    end
  end

  // link and register flops; all but frame_q zero after reset, which is every field default
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_q                       <= 1'b0;
      frame_q                      <= 1'b1;
      shift_in                     <= '0;
      bit_cnt                      <= '0;
      reading                      <= 1'b0;
      shift_out                    <= '0;
      low_power_control            <= '0;
      calibration_modulator_config <= '0;
      pin_and_fast_lock_config     <= '0;
      regulator_config             <= '0;
      test_initialization          <= '0;
    end else begin
      sclk_q                       <= next_sclk_q;
      frame_q                      <= next_frame_q;
      shift_in                     <= next_shift_in;
      bit_cnt                      <= next_bit_cnt;
      reading                      <= next_reading;
      shift_out                    <= next_shift_out;
      low_power_control            <= next_low_power;
      calibration_modulator_config <= next_cal_mod;
      pin_and_fast_lock_config     <= next_pin_fast;
      regulator_config             <= next_regulator;
      test_initialization          <= next_test_init;
    end
  end

  // decoded controls, shared pin and fast-lock timer
  logic              fl_pin_q;                  // previous fast-lock pin level
  logic [DUR_W-1:0]  fl_count;                  // pfd ticks left in the slot
  logic [DUR_W-1:0]  next_fl_count;
  logic              next_fl_active;
  logic [2:0]        next_stages;
  logic [8:0]        next_div_ratio;
  logic [2:0]        next_precharge;
  logic [1:0]        next_extra;
  logic              next_pin_out, next_pin_oe;
  logic              pin_value;                 // logical value for the pin
  logic              next_rf2_pd;
  logic [1:0]        order_code;
  logic [8:0]        div_code;
  pin_source_e       source;

  always_comb begin
    order_code = calibration_modulator_config[MODULATOR_ORDER_LO +: 2];
    div_code   = calibration_modulator_config[CAL_DIVIDER_LO +: 9];
    source     = pin_source_e'(pin_and_fast_lock_config[SHARED_PIN_SOURCE_LO +: 2]);
    case (order_code)
      2'h0:    next_stages = 3'h3;
      2'h1:    next_stages = 3'h2;
      2'h2:    next_stages = 3'h1;
      default: next_stages = 3'h4;
    endcase
    next_div_ratio = (div_code == '0) ? CAL_DIVIDER_MAX : div_code;
    next_precharge = {1'b0, calibration_modulator_config[PRECHARGE_SLOTS_LO +: 2]}
                     + 3'h1;
    next_extra = calibration_modulator_config[CALIBRATION_ACCURACY_BOOST] ?
                 EXTRA_SLOTS : 2'h0;
    // second stage follows the first pin when its own pin is ignored
    next_rf2_pd = regulator_config[SECOND_POWERDOWN_PIN_IGNORE] ?
                  rf1_powerdown_pin : rf2_powerdown_pin;
    // fast-lock slot: a rising switch pin starts it, pfd ticks drain it
    next_fl_count = fl_count;
    if (!pin_and_fast_lock_config[FAST_LOCK_ENABLE]) begin
      next_fl_count = '0;
    end else if (fast_lock_switch_pin && !fl_pin_q) begin
      next_fl_count = pin_and_fast_lock_config[FAST_LOCK_DURATION_LO +: DUR_W];
    end else if (pfd_tick && fl_count != '0) begin
      next_fl_count = fl_count - 1'b1;
    end
    next_fl_active = (next_fl_count != '0);
    // shared pin source: read data wins over the multiplexer
    case (source)
      SRC_LOCK:     pin_value = pll_locked;
      SRC_VCO_DIV:  pin_value = vco_divider_clock;
      SRC_CAL_DIV:  pin_value = cal_divider_clock;
      SRC_FAST_CLK: pin_value = fast_lock_clock;
      default:      pin_value = pll_locked;
    endcase
    if (reading) begin
      pin_value = shift_out[REG_W-1];
    end
    // open drain only ever pulls low; push-pull drives both levels
    if (pin_and_fast_lock_config[SHARED_PIN_HIGH_Z]) begin
      next_pin_out = 1'b0;
      next_pin_oe  = 1'b0;
    end else if (pin_and_fast_lock_config[SHARED_PIN_DRIVER_TYPE]) begin
      next_pin_out = pin_value;
      next_pin_oe  = 1'b1;
    end else begin
      next_pin_out = 1'b0;
      next_pin_oe  = !pin_value;
    end
  end

  // registered copies; the pin lags its source by one cycle
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      fl_pin_q                 <= 1'b0;
      fl_count                 <= '0;
      fast_lock_active         <= 1'b0;
      fast_lock_pump_current   <= '0;
      modulator_stages         <= 3'h3;
      calibration_divide_ratio <= CAL_DIVIDER_MAX;
      precharge_slot_count     <= 3'h1;
      calibration_extra_slots  <= 2'h0;
      rf1_powered_down         <= 1'b0;
      rf2_powered_down         <= 1'b0;
      spi.pin_out              <= 1'b0;
      spi.pin_oe               <= 1'b0;
    end else begin
      fl_pin_q                 <= fast_lock_switch_pin;
      fl_count                 <= next_fl_count;
      fast_lock_active         <= next_fl_active;
      fast_lock_pump_current   <= pin_and_fast_lock_config[FAST_LOCK_PUMP_CURRENT_LO +: 5];
      modulator_stages         <= next_stages;
      calibration_divide_ratio <= next_div_ratio;
      precharge_slot_count     <= next_precharge;
      calibration_extra_slots  <= next_extra;
      rf1_powered_down         <= rf1_powerdown_pin;
      rf2_powered_down         <= next_rf2_pd;
      spi.pin_out              <= next_pin_out;
      spi.pin_oe               <= next_pin_oe;
    end
  end
endmodule : synth_config_device

// >>> hw/synth_config_host.sv
// host controller end: turns command-port writes into serial register frames
`timescale 1ns/10ps
module synth_config_host
  import synth_regs_pkg::*;
#(
  parameter int SCLK_HALF      = 4,   // clock cycles per serial clock phase, at least 3
  parameter bit AUTO_RESTART_OK = 1'b1 // variant supports calibration auto-restart
) (
  input  wire logic          clock,
  input  wire logic          sys_rst,
  synth_spi_if.host          spi,
  input  wire logic [3:0]    address,
  input  wire logic [31:0]   write_data,
  input  wire logic          write_strobe,
  input  wire logic          read_strobe,
  output logic [31:0]        read_data
);
  import synth_regs_pkg::*;

  typedef enum logic [1:0] {IDLE, LOW, HIGH, GAP} host_state_e;

  // clears bits the device must never see set
  function automatic logic [FRAME_W-1:0] scrub(input logic [FRAME_W-1:0] f);
    scrub = f;
    if (!f[RW_BIT]) begin
      case (f[ADDR_HI:ADDR_LO])
        OFS_LOW_POWER: scrub[REG_W-1:0] = f[REG_W-1:0] & LOW_POWER_USED_MASK;
        OFS_TEST_INIT: scrub[REG_W-1:0] = '0;
        OFS_CAL_MOD:   scrub[CALIBRATION_AUTO_RESTART] =
                         f[CALIBRATION_AUTO_RESTART] & AUTO_RESTART_OK;
        default: begin
        end
      endcase
    end
  endfunction : scrub

  host_state_e        state, next_state;        // frame sequencer
  logic [7:0]         div_cnt, next_div_cnt;    // phase timer
  logic [CNT_W-1:0]   bit_cnt, next_bit_cnt;    // bits sent
  logic [FRAME_W-1:0] frame, next_frame;        // outgoing bits, msb first
  logic [REG_W-1:0]   capture, next_capture;    // sampled shared pin
  logic [REG_W-1:0]   result, next_result;      // last read word
  logic               next_sclk, next_frame_n, next_sdi;
  logic [31:0]        next_read_data;
  logic               phase_done;

  // sequencer: high phase ends by setting data, low phase ends by sampling the pin
  always_comb begin
    phase_done     = (div_cnt == 8'(SCLK_HALF - 1));
    next_state     = state;
    next_div_cnt   = phase_done ? 8'h00 : div_cnt + 8'h01;
    next_bit_cnt   = bit_cnt;
    next_frame     = frame;
    next_capture   = capture;
    next_result    = result;
    next_sclk      = spi.sclk;
    next_frame_n   = spi.frame_n;
    next_sdi       = spi.sdi;
    case (state)
      IDLE: begin
        next_div_cnt = 8'h00;
        // a command while busy is ignored
        if (write_strobe && address == HOST_CMD) begin
          next_frame   = scrub(write_data);
          next_sdi     = next_frame[FRAME_W-1];
          next_frame_n = 1'b0;
          next_bit_cnt = '0;
          next_state   = LOW;
        end
      end
      LOW: if (phase_done) begin
        next_sclk    = 1'b1;
        next_capture = {capture[REG_W-2:0], spi.pin_level};
        next_state   = HIGH;
      end
      HIGH: if (phase_done) begin
        next_sclk    = 1'b0;
        next_bit_cnt = bit_cnt + 1'b1;
        // rotate rather than shift: after 32 bits the word is whole again,
        // so the gap phase still finds the read flag in its top bit
        next_frame   = {frame[FRAME_W-2:0], frame[FRAME_W-1]};
        if (bit_cnt == CNT_W'(FRAME_W - 1)) begin
          next_frame_n = 1'b1;
          next_sdi     = 1'b0;
          next_state   = GAP;
        end else begin
          next_sdi   = frame[FRAME_W-2];
          next_state = LOW;
        end
      end
      GAP: if (phase_done) begin
        if (frame[RW_BIT]) begin
          next_result = capture;
        end
        next_state = IDLE;
      end
      default: next_state = IDLE;
    endcase
    next_read_data = '0;
    if (read_strobe) begin
      case (address)
        HOST_STATUS: next_read_data = {31'h0000_0000, state != IDLE};
        HOST_RDATA:  next_read_data = {5'h00, result};
        default:     next_read_data = '0;
      endcase
    end
  end

  // registers only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= IDLE;
      div_cnt     <= '0;
      bit_cnt     <= '0;
      frame       <= '0;
      capture     <= '0;
      result      <= '0;
      spi.sclk    <= 1'b0;
      spi.frame_n <= 1'b1;
      spi.sdi     <= 1'b0;
      read_data   <= '0;
    end else begin
      state       <= next_state;
      div_cnt     <= next_div_cnt;
      bit_cnt     <= next_bit_cnt;
      frame       <= next_frame;
      capture     <= next_capture;
      result      <= next_result;
      spi.sclk    <= next_sclk;
      spi.frame_n <= next_frame_n;
      spi.sdi     <= next_sdi;
      read_data   <= next_read_data;
    end
  end
endmodule : synth_config_host

// >>> tb/synth_link_sva.sv
// concurrent checks on the serial link and on the decoded device fields
`timescale 1ns/10ps
module synth_link_sva (
  input wire logic        clock, sys_rst, frame_n, sclk, pin_oe, pin_out,
  input wire logic [26:0] low_power_control, calibration_modulator_config,
  input wire logic [26:0] pin_and_fast_lock_config, test_initialization,
  input wire logic [2:0]  modulator_stages, precharge_slot_count,
  input wire logic [8:0]  calibration_divide_ratio,
  input wire logic [1:0]  calibration_extra_slots
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // short aliases; decodes are judged only once a word has sat still two edges
  wire logic [26:0] cm = calibration_modulator_config;
  wire logic [26:0] pf = pin_and_fast_lock_config;
  idle_clock_a: assert property (frame_n |-> !sclk) else $error("clock outside frame");
  order_map_a: assert property (cm == $past(cm, 2) |->
    modulator_stages == ((cm[23:22] == 2'h3) ? 3'h4 : 3'h3 - cm[23:22])) else $error("order");
  div_zero_a: assert property (cm == $past(cm, 2) |->
    calibration_divide_ratio == ((cm[8:0] == 9'h000) ? 9'h1ff : cm[8:0])) else $error("ratio");
  precharge_map_a: assert property (cm == $past(cm, 2) |->
    precharge_slot_count == {1'b0, cm[11:10]} + 3'h1) else $error("precharge");
  extra_slots_a: assert property (cm == $past(cm, 2) |->
    calibration_extra_slots == (cm[9] ? 2'h2 : 2'h0)) else $error("extra slots");
  high_z_a: assert property (pf[25] && $past(pf[25]) && $past(pf[25], 2) |-> !pin_oe)
    else $error("pin driven in high z");
  open_drain_a: assert property (!pf[24] && !$past(pf[24]) |-> !(pin_oe && pin_out))
    else $error("open drain drove high");
  test_zero_a: assert property (test_initialization == 27'h000_0000) else $error("test reg");
  reserved_zero_a: assert property ((low_power_control & ~27'h000_0015) == 27'h000_0000)
    else $error("reserved bits");
endmodule : synth_link_sva

// >>> tb/synth_config_status_regs_tb.sv
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/10ps
module synth_config_status_regs_tb;
  import synth_regs_pkg::*;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, e, g); end end
  logic clock = 0, sys_rst = 1, write_strobe = 0, read_strobe = 0;
  logic [3:0]  address = 4'h0;
  logic [31:0] write_data = 32'h0000_0000, read_data, q;
  logic pll_locked = 1, fl_pin = 0, rf1 = 0, rf2 = 0, pfd_tick = 0;
  logic [4:0]  reg_ok = 5'h15, reg_oc = 5'h0a, band = 5'h1b;
  logic [1:0]  osc = 2'h2, calibration_extra_slots;
  logic [26:0] low_power_control, calibration_modulator_config, pin_and_fast_lock_config;
  logic [26:0] test_initialization, regulator_config;
  logic [4:0]  fast_lock_pump_current;
  logic [2:0]  modulator_stages, precharge_slot_count;
  logic [8:0]  calibration_divide_ratio;
  logic        rf1_powered_down, rf2_powered_down, fast_lock_active;
  int          n_errors = 0, n_checks = 0;
  synth_spi_if link ();
  synth_config_device synth_config_device_inst (.clock, .sys_rst, .spi(link), .pll_locked,
    .vco_divider_clock(1'b0), .cal_divider_clock(1'b0), .fast_lock_clock(1'b0),
    .fast_lock_switch_pin(fl_pin), .rf1_powerdown_pin(rf1), .rf2_powerdown_pin(rf2), .pfd_tick,
    .regulator_started(reg_ok), .regulator_overcurrent(reg_oc), .calibrated_oscillator(osc),
    .calibrated_subband(band), .low_power_control, .calibration_modulator_config,
    .pin_and_fast_lock_config, .regulator_config, .test_initialization, .modulator_stages,
    .calibration_divide_ratio, .precharge_slot_count, .calibration_extra_slots,
    .rf1_powered_down, .rf2_powered_down, .fast_lock_active, .fast_lock_pump_current);
  synth_config_host #(.SCLK_HALF(3)) synth_config_host_inst (.clock, .sys_rst, .spi(link),
    .address, .write_data, .write_strobe, .read_strobe, .read_data);
  synth_link_sva synth_link_sva_inst (.clock, .sys_rst, .frame_n(link.frame_n),
    .sclk(link.sclk), .pin_oe(link.pin_oe), .pin_out(link.pin_out), .low_power_control,
    .calibration_modulator_config, .pin_and_fast_lock_config, .test_initialization,
    .modulator_stages, .precharge_slot_count, .calibration_divide_ratio,
    .calibration_extra_slots);
  initial forever #5 clock = ~clock;
  // one-cycle command port accesses; read data is taken in the cycle after the strobe
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock); address <= a; write_data <= d; write_strobe <= 1'b1;
    @(posedge clock); write_strobe <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge clock); address <= a; read_strobe <= 1'b1;
    @(posedge clock); read_strobe <= 1'b0; #1 q = read_data;
  endtask : rd
  // send one frame and poll busy under a bound, then let the device commit land
  task frame(input logic [31:0] d);
    int n;
    wr(HOST_CMD, d); n = 0;
    do begin rd(HOST_STATUS); n++; end while (q[0] !== 1'b0 && n < 300);
    if (q[0] !== 1'b0) n_errors++;
    repeat (4) @(posedge clock);
  endtask : frame
  task get(input logic [3:0] i);
    frame({1'b1, i, 27'h000_0000}); rd(HOST_RDATA);
  endtask : get
  task t_cal;
    logic [26:0] v;
    for (int k = 0; k < 4; k++) begin
      v = 27'h400_0200 | (27'(k) << 22) | (27'(k) << 10) | 27'(k);
      frame({1'b0, OFS_CAL_MOD, v});
      `CHK("order", (k == 3) ? 3'h4 : 3'(3 - k), modulator_stages)
      `CHK("slots", 3'(k + 1), precharge_slot_count)
      `CHK("ratio", (k == 0) ? 9'h1ff : 9'(k), calibration_divide_ratio)
      `CHK("extra", 2'h2, calibration_extra_slots)
      get(OFS_CAL_MOD); `CHK("rb6", v, q[26:0])
    end
    $display("test cal done");
  endtask : t_cal
  task t_lp;
    frame({1'b0, OFS_LOW_POWER, 27'h7ff_ffff}); get(OFS_LOW_POWER);
    `CHK("lp", 27'h000_0015, q[26:0])
    frame({1'b0, OFS_TEST_INIT, 27'h7ff_ffff});
    `CHK("test", 27'h000_0000, test_initialization)
    rd(4'hf); `CHK("unmapped", 32'h0000_0000, q)
    $display("test low power done");
  endtask : t_lp
  task t_st;
    frame({1'b0, OFS_STATUS, 27'h7ff_ffff}); get(OFS_STATUS);
    `CHK("status", {9'h000, 5'h15, 5'h0a, 1'b1, 2'h2, 5'h1b}, q[26:0])
    pll_locked <= 1'b0; get(OFS_STATUS); `CHK("lock", 1'b0, q[7])
    $display("test status done");
  endtask : t_st
  task t_pin;
    frame({1'b0, OFS_REGULATOR, 27'h400_0003}); rf1 <= 1'b1;
    repeat (3) @(posedge clock); `CHK("rf2pd", 1'b1, rf2_powered_down)
    `CHK("rf1pd", 1'b1, rf1_powered_down)
    `CHK("reg8", 27'h400_0003, regulator_config)
    frame({1'b0, OFS_PIN_FAST, 27'h200_0000}); get(OFS_PIN_FAST);
    `CHK("highz", 27'h7ff_ffff, q[26:0])
    frame({1'b0, OFS_PIN_FAST, 27'h106_2003}); get(OFS_PIN_FAST);
    `CHK("rb7", 27'h106_2003, q[26:0])
    `CHK("flcur", 5'h11, fast_lock_pump_current)
    @(posedge clock); fl_pin <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      repeat (3) @(posedge clock); `CHK("fl on", 1'b1, fast_lock_active)
      pfd_tick <= 1'b1; @(posedge clock); pfd_tick <= 1'b0;
    end
    repeat (3) @(posedge clock); `CHK("fl off", 1'b0, fast_lock_active)
    frame({1'b0, OFS_PIN_FAST, 27'h080_0000}); get(OFS_PIN_FAST);
    `CHK("nosdo", 27'h000_0000, q[26:0])
    $display("test pin done");
  endtask : t_pin
  task summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(posedge clock); sys_rst <= 1'b0;
    frame({1'b0, OFS_TEST_INIT, 27'h000_0000});
    for (int i = 8; i >= 5; i--) frame({1'b0, 4'(i), 27'h000_0000});
    t_cal; t_lp; t_st; t_pin; summarize;
  end
  initial begin
    #400_000; n_errors++; summarize;
  end
endmodule : synth_config_status_regs_tb
